// ===== hw/lup_regs.vh
// Constants used by the user data port, including its CRC polynomial, initial value and final XOR.
`ifndef LUP_REGS_VH
`define LUP_REGS_VH
`define LUP_LANE_BITS 64
`define LUP_LANE_BYTES 8
`define LUP_BYTE_BITS 8
`define LUP_CRC_POLY 32'h04C1_1DB7
`define LUP_CRC_INIT 32'hFFFF_FFFF
`define LUP_CRC_XOR 32'hFFFF_FFFF
`endif

// ===== hw/lup_skid_buf.v
// Two-entry buffer with registered ready, valid and data.
`timescale 1ns/10ps
module lup_skid_buf #(
   parameter WIDTH = 73
) (
   input wire ref_clk_in,
   input wire sys_rst_in,
   input wire in_valid_in,
   input wire [WIDTH-1:0] in_data_in,
   output wire in_ready_out,
   output wire out_valid_out,
   output wire [WIDTH-1:0] out_data_out,
   input wire out_ready_in
);
   reg main_valid_reg;
   reg [WIDTH-1:0] main_data_reg;
   reg skid_valid_reg;
   reg [WIDTH-1:0] skid_data_reg;
   reg ready_reg;
   wire push;
   wire pop;

   assign push = in_valid_in & ready_reg;
   assign pop = main_valid_reg & out_ready_in;
   assign in_ready_out = ready_reg;
   assign out_valid_out = main_valid_reg;
   assign out_data_out = main_data_reg;

   // ****************************************
   // Storage.
   // ****************************************
   always @(posedge ref_clk_in) begin
      if (sys_rst_in) begin
         main_valid_reg <= 1'b0;
         skid_valid_reg <= 1'b0;
         ready_reg <= 1'b1;
         main_data_reg <= {WIDTH{1'b0}};
         skid_data_reg <= {WIDTH{1'b0}};
      end else if (skid_valid_reg) begin
         if (pop) begin
            main_data_reg <= skid_data_reg;
            skid_valid_reg <= 1'b0;
            ready_reg <= 1'b1;
         end
      end else if (push) begin
         if (!main_valid_reg || pop) begin
            main_data_reg <= in_data_in;
            main_valid_reg <= 1'b1;
         end else begin
            skid_data_reg <= in_data_in;
            skid_valid_reg <= 1'b1;
            ready_reg <= 1'b0;
         end
      end else if (pop) begin
         main_valid_reg <= 1'b0;
      end
   end
endmodule

// ===== hw/lup_user_data_port.v
// User data port: framed and streaming transmit and receive beats.
`timescale 1ns/10ps
`include "lup_regs.vh"
// Function
// - Transmit data bus is 64 bits per lane, bits numbered ascending.
// - A transmit beat is taken only when ready and valid are both high.
// - Keep's set-bit count gives valid bytes in the final beat.
// - Transmit keep is used only on beats with last high.
// - Both aligned and unaligned contiguous transmit streams are accepted.
// - Receive data is 64 bits per lane, bits numbered ascending.
// - Receive keep shows valid bytes of the final beat, meaningful with last.
// - Receive valid is high only when receive outputs are meaningful.
// - Receive last pulses for one cycle at each frame end.
// - Full-duplex and receive-only cores carry the streaming receive ports.
// - With the CRC option in framed mode a 32-bit CRC covers every transmit frame.
// - Full-duplex has both directions; simplex only its own direction.
module lup_user_data_port #(
   parameter LANES = 1,
   parameter HAS_TX = 1,
   parameter HAS_RX = 1,
   parameter CRC_EN = 1
) (
   input wire ref_clk_in,
   input wire sys_rst_in,
   input wire framed_mode_in,
   input wire [0:`LUP_LANE_BITS*LANES-1] s_tx_tdata_in,
   input wire s_tx_tvalid_in,
   input wire s_tx_tlast_in,
   input wire [0:`LUP_LANE_BYTES*LANES-1] s_tx_tkeep_in,
   output wire s_tx_tready_out,
   output wire [0:`LUP_LANE_BITS*LANES-1] pe_tx_data_out,
   output wire pe_tx_valid_out,
   output wire pe_tx_last_out,
   output wire [0:`LUP_LANE_BYTES*LANES-1] pe_tx_keep_out,
   input wire pe_tx_ready_in,
   output reg [31:0] tx_crc_out,
   output reg tx_crc_valid_out,
   input wire [0:`LUP_LANE_BITS*LANES-1] pe_rx_data_in,
   input wire pe_rx_valid_in,
   input wire pe_rx_last_in,
   input wire [0:`LUP_LANE_BYTES*LANES-1] pe_rx_keep_in,
   output reg [0:`LUP_LANE_BITS*LANES-1] m_rx_tdata_out,
   output reg m_rx_tvalid_out,
   output reg m_rx_tlast_out,
   output reg [0:`LUP_LANE_BYTES*LANES-1] m_rx_tkeep_out
);
   localparam DW = `LUP_LANE_BITS * LANES;
   localparam KW = `LUP_LANE_BYTES * LANES;
   localparam BW = DW + 1 + KW;

   wire tx_ready;
   wire tx_push;
   wire [0:KW-1] tx_keep_eff;
   wire tx_last_eff;
   wire buf_valid;
   wire [BW-1:0] buf_data;
   reg [31:0] crc_run_reg;
   reg [31:0] crc_next;

   // ****************************************
   // CRC over the bytes that keep marks.
   // ****************************************
   function [31:0] lup_crc_beat;
      input [31:0] crc_in;
      input [0:DW-1] data;
      input [0:KW-1] keep;
      integer i;
      integer b;
      reg [31:0] c;
      begin
         c = crc_in;
         for (i = 0; i < KW; i = i + 1) begin
            if (keep[i]) begin
               for (b = 0; b < `LUP_BYTE_BITS; b = b + 1) begin
                  if (c[31] ^ data[i*`LUP_BYTE_BITS+b]) begin
                     c = {c[30:0], 1'b0} ^ `LUP_CRC_POLY;
                  end else begin
                     c = {c[30:0], 1'b0};
                  end
               end
            end
         end
         lup_crc_beat = c;
      end
   endfunction

   // ****************************************
   // Transmit path.
   // ****************************************
   // Streaming beats carry no last; keep counts only on a last beat.
   assign tx_last_eff = framed_mode_in & s_tx_tlast_in;
   assign tx_keep_eff = tx_last_eff ? s_tx_tkeep_in : {KW{1'b1}};
   assign tx_push = s_tx_tvalid_in & tx_ready;

   generate
      if (HAS_TX != 0) begin : g_tx
         lup_skid_buf #(
            .WIDTH(BW)
         ) u_tx_buf (
            .ref_clk_in(ref_clk_in),
            .sys_rst_in(sys_rst_in),
            .in_valid_in(s_tx_tvalid_in),
            .in_data_in({s_tx_tdata_in, tx_last_eff, tx_keep_eff}),
            .in_ready_out(tx_ready),
            .out_valid_out(buf_valid),
            .out_data_out(buf_data),
            .out_ready_in(pe_tx_ready_in)
         );
      end else begin : g_no_tx
         // A receive-only core never accepts transmit beats.
         reg zero_reg;
         always @(posedge ref_clk_in) begin
            zero_reg <= 1'b0;
         end
         assign tx_ready = zero_reg;
         assign buf_valid = zero_reg;
         assign buf_data = {BW{zero_reg}};
      end
   endgenerate

   assign s_tx_tready_out = tx_ready;
   assign pe_tx_valid_out = buf_valid;
   assign pe_tx_data_out = buf_data[BW-1:KW+1];
   assign pe_tx_last_out = buf_data[KW];
   assign pe_tx_keep_out = buf_data[KW-1:0];

   always @* begin
      crc_next = lup_crc_beat(crc_run_reg, s_tx_tdata_in, tx_keep_eff);
   end

   always @(posedge ref_clk_in) begin
      if (sys_rst_in) begin
         crc_run_reg <= `LUP_CRC_INIT;
         tx_crc_out <= 32'h0000_0000;
         tx_crc_valid_out <= 1'b0;
      end else begin
         tx_crc_valid_out <= 1'b0;
         if (tx_push && framed_mode_in && CRC_EN != 0) begin
            if (tx_last_eff) begin
               crc_run_reg <= `LUP_CRC_INIT;
               tx_crc_out <= crc_next ^ `LUP_CRC_XOR;
               tx_crc_valid_out <= 1'b1;
            end else begin
               crc_run_reg <= crc_next;
            end
         end
      end
   end

   // ****************************************
   // Receive path.
   // ****************************************
   // The sink has no ready, so every beat passes straight through a register.
   always @(posedge ref_clk_in) begin
      if (sys_rst_in || HAS_RX == 0) begin
         m_rx_tvalid_out <= 1'b0;
         m_rx_tlast_out <= 1'b0;
      end else begin
         m_rx_tvalid_out <= pe_rx_valid_in;
         m_rx_tlast_out <= pe_rx_valid_in & pe_rx_last_in & framed_mode_in;
      end
   end

   // ****************************************
   // Receive data and keep, one slice per lane.
   // ****************************************
   genvar ln;
   generate
      for (ln = 0; ln < LANES; ln = ln + 1) begin : g_rx_lane
         always @(posedge ref_clk_in) begin
            if (sys_rst_in || HAS_RX == 0) begin
               m_rx_tdata_out[ln*`LUP_LANE_BITS +: `LUP_LANE_BITS] <= {`LUP_LANE_BITS{1'b0}};
               m_rx_tkeep_out[ln*`LUP_LANE_BYTES +: `LUP_LANE_BYTES] <= {`LUP_LANE_BYTES{1'b0}};
            end else if (pe_rx_valid_in) begin
               m_rx_tdata_out[ln*`LUP_LANE_BITS +: `LUP_LANE_BITS] <=
                  pe_rx_data_in[ln*`LUP_LANE_BITS +: `LUP_LANE_BITS];
               if (framed_mode_in && pe_rx_last_in) begin
                  m_rx_tkeep_out[ln*`LUP_LANE_BYTES +: `LUP_LANE_BYTES] <=
                     pe_rx_keep_in[ln*`LUP_LANE_BYTES +: `LUP_LANE_BYTES];
               end else begin
                  m_rx_tkeep_out[ln*`LUP_LANE_BYTES +: `LUP_LANE_BYTES] <= {`LUP_LANE_BYTES{1'b1}};
               end
            end
         end
      end
   endgenerate
endmodule

// ===== verification/lup_user_data_port_properties.sv
// Checker on the ports of the user data port.
`timescale 1ns/10ps
module lup_udp_props (
   input wire ref_clk_in, sys_rst_in, framed_mode_in, s_tx_tvalid_in, s_tx_tlast_in, s_tx_tready_out,
   input wire pe_tx_valid_out, pe_tx_last_out, pe_tx_ready_in, tx_crc_valid_out,
   input wire pe_rx_valid_in, pe_rx_last_in, m_rx_tvalid_out, m_rx_tlast_out,
   input wire [0:63] s_tx_tdata_in, pe_tx_data_out, pe_rx_data_in, m_rx_tdata_out,
   input wire [0:7] pe_tx_keep_out, pe_rx_keep_in, m_rx_tkeep_out
);
   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (sys_rst_in);
   sequence s_take; s_tx_tvalid_in && s_tx_tready_out; endsequence
   sequence s_rx_end; pe_rx_valid_in && pe_rx_last_in && framed_mode_in; endsequence
   property p_rx_beat; pe_rx_valid_in |=> m_rx_tvalid_out && m_rx_tdata_out == $past(pe_rx_data_in); endproperty
   a_rx_beat: assert property (p_rx_beat) else $error("rx beat lost");
   property p_rx_idle; !pe_rx_valid_in |=> !m_rx_tvalid_out && !m_rx_tlast_out; endproperty
   a_rx_idle: assert property (p_rx_idle) else $error("rx valid without beat");
   property p_rx_end; s_rx_end |=> m_rx_tlast_out && m_rx_tkeep_out == $past(pe_rx_keep_in); endproperty
   a_rx_end: assert property (p_rx_end) else $error("rx frame end wrong");
   property p_rx_mid; m_rx_tvalid_out && !m_rx_tlast_out |-> m_rx_tkeep_out == 8'hFF; endproperty
   a_rx_mid: assert property (p_rx_mid) else $error("rx keep on inner beat");
   property p_tx_first;
      s_take ##0 !pe_tx_valid_out |=> pe_tx_valid_out && pe_tx_data_out == $past(s_tx_tdata_in);
   endproperty
   a_tx_first: assert property (p_tx_first) else $error("tx beat not forwarded");
   property p_tx_hold;
      pe_tx_valid_out && !pe_tx_ready_in |=> pe_tx_valid_out && $stable(pe_tx_data_out);
   endproperty
   a_tx_hold: assert property (p_tx_hold) else $error("tx beat dropped");
   property p_tx_keep; pe_tx_valid_out && !pe_tx_last_out |-> pe_tx_keep_out == 8'hFF; endproperty
   a_tx_keep: assert property (p_tx_keep) else $error("tx keep on inner beat");
   property p_stream; !framed_mode_in && pe_tx_valid_out |-> !pe_tx_last_out; endproperty
   a_stream: assert property (p_stream) else $error("last in streaming");
   property p_crc; s_take ##0 s_tx_tlast_in && framed_mode_in |=> tx_crc_valid_out; endproperty
   a_crc: assert property (p_crc) else $error("crc not presented");
endmodule
bind lup_user_data_port lup_udp_props props_i (.*);

// ===== verification/lup_engine_model.sv
// Engine model: takes transmit beats with optional stall and sends receive beats.
`timescale 1ns/10ps
module lup_engine_model (
   input wire ref_clk_in, stall_in, pe_tx_valid_out, pe_tx_last_out,
   input wire [0:63] pe_tx_data_out,
   input wire [0:7] pe_tx_keep_out,
   output reg pe_tx_ready_in = 1'b1, pe_rx_valid_in = 1'b0, pe_rx_last_in = 1'b0,
   output reg [0:63] pe_rx_data_in = 64'h0000_0000_0000_0000,
   output reg [0:7] pe_rx_keep_in = 8'h00
);
   reg [0:72] got[$];
   always @(posedge ref_clk_in) begin
      if (pe_tx_valid_out && pe_tx_ready_in) got.push_back({pe_tx_data_out, pe_tx_last_out, pe_tx_keep_out});
      pe_tx_ready_in <= !stall_in;
   end
   task rx_beat(input [0:63] d, input l, input [0:7] k);
      begin
         {pe_rx_valid_in, pe_rx_last_in, pe_rx_keep_in, pe_rx_data_in} = {1'b1, l, k, d};
         @(posedge ref_clk_in);
         #1;
      end
   endtask
   // Valid and last drop to zero; keep and data show the inverse of their last value.
   task rx_idle;
      {pe_rx_valid_in, pe_rx_last_in, pe_rx_keep_in, pe_rx_data_in} = {2'b00, ~pe_rx_keep_in, ~pe_rx_data_in};
   endtask
endmodule

// ===== verification/tb.sv
// Self-checking bench for the user data port.
`timescale 1ns/10ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin num_errors++; $display("Error %0t: got %h", $time, a); end end
module tb;
   localparam [0:63] D0 = 64'h0123_4567_89AB_CDEF, D1 = 64'hFEDC_BA98_7654_3210, D2 = 64'hA5A5_5A5A_C3C3_3C3C;
   reg ref_clk_in, sys_rst_in, framed_mode_in, s_tx_tvalid_in, s_tx_tlast_in, stall_in;
   reg [0:63] s_tx_tdata_in;
   reg [0:7] s_tx_tkeep_in;
   reg [31:0] crc_seen;
   wire s_tx_tready_out, pe_tx_valid_out, pe_tx_last_out, pe_tx_ready_in, tx_crc_valid_out;
   wire pe_rx_valid_in, pe_rx_last_in, m_rx_tvalid_out, m_rx_tlast_out;
   wire [0:63] pe_tx_data_out, pe_rx_data_in, m_rx_tdata_out;
   wire [0:7] pe_tx_keep_out, pe_rx_keep_in, m_rx_tkeep_out;
   wire [31:0] tx_crc_out;
   int num_errors = 0, compares = 0;
   lup_user_data_port lup_user_data_port_i (.*);
   lup_engine_model lup_engine_model_i (.*);
   always @(posedge ref_clk_in) if (tx_crc_valid_out === 1'b1) crc_seen <= tx_crc_out;
   function [31:0] crc_step(input [31:0] c, input [0:63] d, input int nb);
      for (int i = 0; i < nb * 8; i++) c = {c[30:0], 1'b0} ^ ((c[31] ^ d[i]) ? 32'h04C1_1DB7 : 32'h0000_0000);
      return c;
   endfunction
   task tx_beat(input [0:63] d, input l, input [0:7] k);
      int n;
      begin
         n = 0;
         {s_tx_tvalid_in, s_tx_tlast_in, s_tx_tkeep_in, s_tx_tdata_in} = {1'b1, l, k, d};
         while (s_tx_tready_out !== 1'b1 && n < 50) begin
            @(posedge ref_clk_in);
            #1 n++;
         end
         @(posedge ref_clk_in);
         #1;
      end
   endtask
   task tx_idle;
      {s_tx_tvalid_in, s_tx_tdata_in} = {1'b0, ~s_tx_tdata_in};
   endtask
   task t_tx_frame;
      begin
         stall_in = 1;
         repeat (2) @(posedge ref_clk_in);
         #1 tx_beat(D0, 0, 8'h00);
         tx_beat(D1, 0, 8'h0F);
         `CHK(s_tx_tready_out, 1'b0)
         stall_in = 0;
         tx_beat(D2, 1, 8'hE0);
         tx_idle;
         repeat (5) @(posedge ref_clk_in);
         #1 `CHK(lup_engine_model_i.got.size(), 3)
         `CHK(lup_engine_model_i.got[0], {D0, 1'b0, 8'hFF})
         `CHK(lup_engine_model_i.got[1], {D1, 1'b0, 8'hFF})
         `CHK(lup_engine_model_i.got[2], {D2, 1'b1, 8'hE0})
         `CHK(crc_seen, crc_step(crc_step(crc_step(32'hFFFF_FFFF, D0, 8), D1, 8), D2, 3) ^ 32'hFFFF_FFFF)
         $display("t_tx_frame done");
      end
   endtask
   task t_rx_frame;
      begin
         lup_engine_model_i.rx_beat(D0, 0, 8'h00);
         `CHK({m_rx_tvalid_out, m_rx_tlast_out, m_rx_tkeep_out, m_rx_tdata_out}, {2'b10, 8'hFF, D0})
         lup_engine_model_i.rx_beat(D1, 1, 8'hF0);
         `CHK({m_rx_tvalid_out, m_rx_tlast_out, m_rx_tkeep_out, m_rx_tdata_out}, {2'b11, 8'hF0, D1})
         lup_engine_model_i.rx_idle;
         @(posedge ref_clk_in);
         #1 `CHK({m_rx_tvalid_out, m_rx_tlast_out}, 2'b00)
         $display("t_rx_frame done");
      end
   endtask
   task t_stream;
      begin
         framed_mode_in = 0;
         tx_beat(D2, 1, 8'h0F);
         tx_idle;
         lup_engine_model_i.rx_beat(D2, 1, 8'h0F);
         `CHK({m_rx_tvalid_out, m_rx_tlast_out, m_rx_tkeep_out, m_rx_tdata_out}, {2'b10, 8'hFF, D2})
         lup_engine_model_i.rx_idle;
         repeat (3) @(posedge ref_clk_in);
         #1 `CHK(lup_engine_model_i.got[3], {D2, 1'b0, 8'hFF})
         framed_mode_in = 1;
         $display("t_stream done");
      end
   endtask
   task final_report;
      begin
         $display("compares %0d mismatches %0d", compares, num_errors);
         if (num_errors == 0 && compares > 0) $display("*** PASS ***");
         else $display("*** FAIL ***");
         $finish;
      end
   endtask
   initial begin
      ref_clk_in = 0;
      forever #2.5 ref_clk_in = ~ref_clk_in;
   end
   initial begin
      #5000 num_errors++;
      final_report;
   end
   initial begin
      {sys_rst_in, framed_mode_in, s_tx_tvalid_in, s_tx_tlast_in, stall_in} = 5'b11000;
      {s_tx_tdata_in, s_tx_tkeep_in} = '0;
      repeat (6) @(posedge ref_clk_in);
      #1 sys_rst_in = 0;
      t_tx_frame;
      t_rx_frame;
      t_stream;
      final_report;
   end
endmodule
